// ===== peripheral_control_status_card.sv
// Behaviour
// - One 16-bit control and status register
// - Bit 15 byte write pointer, zeroed by select three
// - Bit 14 byte read pointer, zeroed by select two
// - Bit 13 selected read FIFO empty
// - Bit 12 selected write FIFO full
// - Bits 11,10 low when word halves full
// - Bits 9,8 low when word halves available
// - Bit 7 drives host interrupt, hardware negates
// - Bit 6 protocol controller interrupt, active low
// - Bit 5 DMA fault nonmaskable interrupt
// - Bits 4,3 DMA end of process
// - Bit 2 bus reset, held while present
// - Bit 1 host control access attention
// - Bit 0 host identity register access
// - Firmware clears event bits 5 to 0 after power-up
// - Firmware memory decoded at upper chip select
// - Identity code written into identity register
`timescale 1ns/100ps
module peripheral_control_status_card
  import peripheral_control_status_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Local processor access
  peripheral_control_status_if.card                       bus,
  // Asynchronous event pins
  input  wire logic                  scsi_irq,
  input  wire logic                  dma_fault,
  input  wire logic                  dma_eop1,
  input  wire logic                  dma_eop0,
  input  wire logic                  scsi_bus_reset,
  input  wire logic                  host_ctrl_access,
  input  wire logic                  host_idvec_access,
  input  wire logic                  host_iack,
  input  wire logic                  host_irq_ack,
  // FIFO status, same clock
  input  wire logic [1:0]            byte_empty,
  input  wire logic [1:0]            byte_full,
  input  wire logic [1:0]            word_full_n,
  input  wire logic [1:0]            word_avail_n,
  input  wire logic [DATA_W-1:0]     fifo_rdata,
  // FIFO strobes and data
  output logic                       fifo_wr,
  output logic                       fifo_rd,
  output logic                       fifo_word,
  output logic                       fifo_sel,
  output logic [DATA_W-1:0]          fifo_wdata,
  output logic                       periph_chip_select_two,
  output logic                       periph_chip_select_three,
  // Firmware memory
  output logic                       upper_chip_select,
  output logic [ROM_WORD_W-1:0]      rom_word,
  input  wire logic [DATA_W-1:0]     rom_rdata,
  // Interrupts and identity
  output logic                       host_interrupt_request_n,
  output logic                       local_irq_zero,
  output logic                       local_irq_one,
  output logic                       local_irq_two,
  output logic                       local_irq_three,
  output logic                       local_nmi,
  output logic [DATA_W-1:0]          id_vector
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [19:0] a, input logic [19:0] t);
    return a == t;
  endfunction

  function automatic logic in_block(input logic [19:0] a, input logic [19:0] b);
    return (a >= b) && (a < b + IO_PS_SIZE);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] sync_q;
  logic [PIN_N-1:0] prev_q;
  logic [PIN_N-1:0] rise;

  assign pins = {host_irq_ack, host_iack, host_idvec_access, host_ctrl_access,
                 scsi_bus_reset, dma_eop0, dma_eop1, dma_fault, scsi_irq};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;

  // ----------------------------------------
  // Access take and decode
  // ----------------------------------------
  logic              ack_q;
  logic              take;
  logic              io;
  logic              byte_wr;
  logic              byte_rd;
  logic              word_wr;
  logic              word_rd;
  logic              ps2;
  logic              ps3;
  logic              rom_hit;
  logic [7:0]        clr;

  // One take per request: ack_q masks the held strobe in the answer cycle
  assign take    = (bus.rd | bus.wr) & ~ack_q;
  assign io      = take & ~bus.mem;
  assign byte_wr = io & bus.wr & hit(bus.addr, IO_BYTE_FIFO);
  assign byte_rd = io & bus.rd & hit(bus.addr, IO_BYTE_FIFO);
  assign word_wr = io & bus.wr & hit(bus.addr, IO_WORD_FIFO);
  assign word_rd = io & bus.rd & hit(bus.addr, IO_WORD_FIFO);
  assign ps2     = io & in_block(bus.addr, IO_PS2_BASE);
  assign ps3     = io & in_block(bus.addr, IO_PS3_BASE);
  assign rom_hit = bus.mem & (bus.addr >= ROM_BASE);

  assign upper_chip_select = rom_hit & (bus.rd | bus.wr);
  assign rom_word          = bus.addr[ROM_WORD_W:1];

  // Clears ignore direction on purpose
  generate
    for (genvar i = 0; i < 8; i++) begin : g_clr
      if (i == B_SPC_IRQ) begin : g_spc
        assign clr[i] = io & hit(bus.addr, IO_SPC_IRQ);
      end else begin : g_bit
        assign clr[i] = io & hit(bus.addr, IO_CLR_BASE + 20'(i));
      end
    end
  endgenerate

  // ----------------------------------------
  // Event latches, bits 6 to 0
  // ----------------------------------------
  logic [EVT_N-1:0] set;
  logic [EVT_N-1:0] evt_q;

  assign set[B_SPC_IRQ] = rise[P_SPC];
  assign set[B_FAULT]   = rise[P_FAULT];
  assign set[B_EOP1]    = rise[P_EOP1];
  assign set[B_EOP0]    = rise[P_EOP0];
  assign set[B_BUS_RST] = sync_q[P_BRST];
  assign set[B_ATTN]    = rise[P_CTRL];
  assign set[B_INIT]    = rise[P_IDV] & ~sync_q[P_IACK];

  // Set wins over a clear in the same cycle
  generate
    for (genvar i = 0; i < EVT_N; i++) begin : g_evt
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          evt_q[i] <= EVT_RESET[i];
        end else if (set[i]) begin
          evt_q[i] <= 1'b1;
        end else if (clr[i]) begin
          evt_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Host interrupt request, bit 7
  // ----------------------------------------
  logic host_irq_n_q;
  logic fw_assert;

  assign fw_assert = io & bus.wr & hit(bus.addr, IO_PERIPHERAL_CONTROL_STATUS) & ~bus.wdata[B_HOST_IRQ];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_irq_n_q <= HOST_IRQ_RESET_N;
    end else if (fw_assert) begin
      host_irq_n_q <= 1'b0;
    end else if (clr[B_HOST_IRQ] | rise[P_HACK]) begin
      host_irq_n_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Byte pointers
  // ----------------------------------------
  logic wr_ptr_q;
  logic rd_ptr_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
    end else if (ps3) begin
      wr_ptr_q <= 1'b0;
    end else if (byte_wr) begin
      wr_ptr_q <= ~wr_ptr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_ptr_q <= 1'b0;
    end else if (ps2) begin
      rd_ptr_q <= 1'b0;
    end else if (byte_rd) begin
      rd_ptr_q <= ~rd_ptr_q;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  logic [DATA_W-1:0] peripheral_control_status;

  assign peripheral_control_status = {wr_ptr_q, rd_ptr_q,
                 byte_empty[rd_ptr_q],
                 byte_full[wr_ptr_q],
                 word_full_n,
                 word_avail_n,
                 host_irq_n_q, evt_q ^ EVT_LOW_MASK};

  // ----------------------------------------
  // FIFO strobes
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_wr   <= 1'b0;
      fifo_rd   <= 1'b0;
      fifo_word <= 1'b0;
      fifo_sel  <= 1'b0;
      periph_chip_select_two   <= 1'b0;
      periph_chip_select_three <= 1'b0;
    end else begin
      fifo_wr   <= byte_wr | word_wr;
      fifo_rd   <= byte_rd | word_rd;
      periph_chip_select_two   <= ps2;
      periph_chip_select_three <= ps3;
      if (byte_wr | byte_rd | word_wr | word_rd) begin
        fifo_word <= word_wr | word_rd;
        fifo_sel  <= byte_wr ? wr_ptr_q : rd_ptr_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_wdata <= '0;
    end else if (byte_wr | word_wr) begin
      fifo_wdata <= bus.wdata;
    end
  end

  // ----------------------------------------
  // Identity register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      id_vector <= '0;
    end else if (io & bus.wr & hit(bus.addr, IO_ID_VECTOR)) begin
      id_vector <= bus.wdata;
    end
  end

  // ----------------------------------------
  // Read data and answer
  // ----------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;

  always_comb begin
    rd_mux = '0;
    if (bus.mem) begin
      if (rom_hit) rd_mux = rom_rdata;
    end else if (hit(bus.addr, IO_PERIPHERAL_CONTROL_STATUS)) begin
      rd_mux = peripheral_control_status;
    end else if (hit(bus.addr, IO_BYTE_FIFO)) begin
      rd_mux = {8'h00, rd_ptr_q ? fifo_rdata[15:8] : fifo_rdata[7:0]};
    end else if (hit(bus.addr, IO_WORD_FIFO)) begin
      rd_mux = fifo_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= take;
      if (take & bus.rd) rdata_q <= rd_mux;
    end
  end

  assign bus.ack   = ack_q;
  assign bus.rdata = rdata_q;

  // ----------------------------------------
  // Interrupt outputs
  // ----------------------------------------
  assign host_interrupt_request_n = host_irq_n_q;
  assign local_irq_zero  = evt_q[B_INIT];
  assign local_irq_one   = evt_q[B_ATTN];
  assign local_irq_two   = evt_q[B_SPC_IRQ] | evt_q[B_BUS_RST];
  assign local_irq_three = evt_q[B_EOP1] | evt_q[B_EOP0];
  assign local_nmi       = evt_q[B_FAULT];

endmodule

// ===== peripheral_control_status_pkg.sv
package peripheral_control_status_pkg;
  // ----------------------------------------
  // Local access widths
  // ----------------------------------------
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 16;
  localparam int ROM_WORD_W = 14;

  // ----------------------------------------
  // Local I/O and memory map
  // ----------------------------------------
  localparam logic [19:0] IO_SPC_IRQ   = 20'h0040D;
  localparam logic [19:0] IO_BYTE_FIFO = 20'h0041F;
  localparam logic [19:0] IO_ID_VECTOR = 20'h00480;
  localparam logic [19:0] IO_PERIPHERAL_CONTROL_STATUS      = 20'h00484;
  localparam logic [19:0] IO_CLR_BASE  = 20'h00488;
  localparam logic [19:0] IO_PS2_BASE  = 20'h00500;
  localparam logic [19:0] IO_PS3_BASE  = 20'h00580;
  localparam logic [19:0] IO_PS_SIZE   = 20'h00080;
  localparam logic [19:0] IO_WORD_FIFO = 20'h00600;
  localparam logic [19:0] ROM_BASE     = 20'hF8000;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int B_WR_PTR = 15, B_RD_PTR = 14, B_EMPTY = 13, B_FULL = 12;
  localparam int B_WFULL1 = 11, B_WFULL0 = 10, B_WAVL1 = 9, B_WAVL0 = 8;
  localparam int B_HOST_IRQ = 7, B_SPC_IRQ = 6, B_FAULT = 5, B_EOP1 = 4;
  localparam int B_EOP0 = 3, B_BUS_RST = 2, B_ATTN = 1, B_INIT = 0;
  localparam int EVT_N = 7;
  localparam logic [6:0] EVT_LOW_MASK = 7'h7C;
  localparam logic [6:0] EVT_RESET    = 7'h00;
  localparam logic       HOST_IRQ_RESET_N = 1'h1;

  // ----------------------------------------
  // Event pin indices
  // ----------------------------------------
  localparam int PIN_N = 9;
  localparam int P_SPC = 0, P_FAULT = 1, P_EOP1 = 2, P_EOP0 = 3, P_BRST = 4;
  localparam int P_CTRL = 5, P_IDV = 6, P_IACK = 7, P_HACK = 8;

  // ----------------------------------------
  // Controller registers (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] WB_CMD    = 8'h00;
  localparam logic [7:0] WB_ADDR   = 8'h04;
  localparam logic [7:0] WB_WDATA  = 8'h08;
  localparam logic [7:0] WB_RDATA  = 8'h0C;
  localparam logic [7:0] WB_STATUS = 8'h10;
  localparam logic [7:0] WB_MASK   = 8'h14;
  localparam int S_DONE = 0, S_REFUSED = 1, S_BUSY = 2;
  localparam logic [1:0] STATUS_RESET = 2'h0;

  // Arbitrary card identity, not a real code
  localparam logic [15:0] CARD_ID   = 16'h5A00;
  localparam logic [2:0]  INIT_LAST = 3'h6;

  typedef enum logic [2:0] {
    OP_IO_RD = 3'b000, OP_IO_WR = 3'b001, OP_BYTE_WR = 3'b010,
    OP_BYTE_RD = 3'b011, OP_WORD_WR = 3'b100, OP_WORD_RD = 3'b101,
    OP_MEM_RD = 3'b110, OP_BAD = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00, ST_IDLE = 2'b01, ST_CHECK = 2'b10, ST_XFER = 2'b11
  } ctrl_state_t;
endpackage

// ===== peripheral_control_status_if.sv
`timescale 1ns/100ps
interface peripheral_control_status_if;
  logic [19:0] addr;
  logic        mem;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;

  modport card (
    input  addr, mem, rd, wr, wdata,
    output rdata, ack
  );
  modport cpu (
    output addr, mem, rd, wr, wdata,
    input  rdata, ack
  );
endinterface

// ===== peripheral_control_status_ctrl.sv
`timescale 1ns/100ps
module peripheral_control_status_ctrl
  import peripheral_control_status_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic [31:0]      wb_dat_r,
  output logic             wb_ack,
  output logic             irq,
  // Card access
  peripheral_control_status_if.cpu              bus
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (n & m);
  endfunction

  function automatic logic check_ok(input op_t op, input logic [15:0] p);
    unique case (op)
      OP_BYTE_WR: return ~p[B_FULL];
      OP_BYTE_RD: return ~p[B_EMPTY];
      OP_WORD_WR: return p[B_WFULL1] & p[B_WFULL0];
      OP_WORD_RD: return ~p[B_WAVL1] & ~p[B_WAVL0];
      default:    return 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // Wishbone registers
  // ----------------------------------------
  ctrl_state_t  state_q;
  op_t          op_q;
  logic [19:0]  addr_q;
  logic [15:0]  wdata_q;
  logic [15:0]  result_q;
  logic [1:0]   status_q;
  logic [1:0]   mask_q;
  logic         ack_q;
  logic         wb_take;
  logic         go;
  logic         busy;
  logic         done_evt;
  logic         ref_evt;
  logic [31:0]  rd_mux;
  logic [31:0]  m_addr;
  logic [31:0]  m_wdata;
  logic [31:0]  m_mask;

  assign wb_take = wb_cyc & wb_stb & ~ack_q;
  assign busy    = state_q != ST_IDLE;
  assign go      = wb_take & wb_we & (wb_adr == WB_CMD) & wb_sel[0] & ~busy;
  assign m_addr  = merge({12'h000, addr_q}, wb_dat_w, wb_sel);
  assign m_wdata = merge({16'h0000, wdata_q}, wb_dat_w, wb_sel);
  assign m_mask  = merge({30'h00000000, mask_q}, wb_dat_w, wb_sel);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_q  <= '0;
      wdata_q <= '0;
      mask_q  <= '0;
    end else if (wb_take & wb_we) begin
      if (wb_adr == WB_ADDR)  addr_q  <= m_addr[19:0];
      if (wb_adr == WB_WDATA) wdata_q <= m_wdata[15:0];
      if (wb_adr == WB_MASK)  mask_q  <= m_mask[1:0];
    end
  end

  // Sticky, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= {ref_evt, done_evt} |
                  (status_q & ~((wb_take & wb_we & (wb_adr == WB_STATUS) & wb_sel[0])
                                ? wb_dat_w[1:0] : 2'h0));
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (wb_adr)
      WB_CMD:    rd_mux = {29'h00000000, op_q};
      WB_ADDR:   rd_mux = {12'h000, addr_q};
      WB_WDATA:  rd_mux = {16'h0000, wdata_q};
      WB_RDATA:  rd_mux = {16'h0000, result_q};
      WB_STATUS: rd_mux = {29'h00000000, busy, status_q};
      WB_MASK:   rd_mux = {30'h00000000, mask_q};
      default:   rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q    <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      ack_q <= wb_take;
      if (wb_take & ~wb_we) wb_dat_r <= rd_mux;
    end
  end

  assign wb_ack = ack_q;
  assign irq    = |(status_q & mask_q);

  // ----------------------------------------
  // Card access sequencer
  // ----------------------------------------
  logic        req_q;
  logic        wr_q;
  logic        mem_q;
  logic [19:0] baddr_q;
  logic [15:0] bwdata_q;
  logic [2:0]  init_cnt_q;
  logic        op_wr;
  logic [19:0] op_addr;

  assign op_wr = (op_q == OP_IO_WR) | (op_q == OP_BYTE_WR) | (op_q == OP_WORD_WR);
  assign op_addr = (op_q == OP_BYTE_WR || op_q == OP_BYTE_RD) ? IO_BYTE_FIFO :
                   (op_q == OP_WORD_WR || op_q == OP_WORD_RD) ? IO_WORD_FIFO : addr_q;

  assign done_evt = (state_q == ST_XFER) & req_q & bus.ack;
  assign ref_evt  = ((state_q == ST_CHECK) & req_q & bus.ack & ~check_ok(op_q, bus.rdata))
                  | (go & (op_t'(wb_dat_w[2:0]) == OP_BAD));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= ST_INIT;
      op_q       <= OP_IO_RD;
      init_cnt_q <= '0;
      result_q   <= '0;
      req_q      <= 1'b0;
      wr_q       <= 1'b0;
      mem_q      <= 1'b0;
      baddr_q    <= '0;
      bwdata_q   <= '0;
    end else if (req_q) begin
      // Request held unchanged until the card answers
      if (bus.ack) begin
        req_q <= 1'b0;
        unique case (state_q)
          ST_INIT: begin
            if (init_cnt_q == INIT_LAST) state_q <= ST_IDLE;
            init_cnt_q <= init_cnt_q + 3'h1;
          end
          ST_CHECK: state_q <= check_ok(op_q, bus.rdata) ? ST_XFER : ST_IDLE;
          ST_XFER: begin
            if (!wr_q) result_q <= bus.rdata;
            state_q <= ST_IDLE;
          end
          ST_IDLE: state_q <= ST_IDLE;
        endcase
      end
    end else begin
      unique case (state_q)
        ST_INIT: begin
          req_q <= 1'b1;
          wr_q  <= 1'b1;
          mem_q <= 1'b0;
          if (init_cnt_q == 3'h0) begin
            baddr_q  <= IO_ID_VECTOR;
            bwdata_q <= CARD_ID;
          end else begin
            baddr_q  <= IO_CLR_BASE + {17'h00000, init_cnt_q - 3'h1};
            bwdata_q <= 16'h0000;
          end
        end
        ST_IDLE: begin
          if (go) begin
            op_q <= op_t'(wb_dat_w[2:0]);
            unique case (op_t'(wb_dat_w[2:0]))
              OP_IO_RD, OP_IO_WR, OP_MEM_RD: state_q <= ST_XFER;
              OP_BAD:                        state_q <= ST_IDLE;
              default:                       state_q <= ST_CHECK;
            endcase
          end
        end
        ST_CHECK: begin
          req_q   <= 1'b1;
          wr_q    <= 1'b0;
          mem_q   <= 1'b0;
          baddr_q <= IO_PERIPHERAL_CONTROL_STATUS;
        end
        ST_XFER: begin
          req_q    <= 1'b1;
          wr_q     <= op_wr;
          mem_q    <= op_q == OP_MEM_RD;
          baddr_q  <= op_addr;
          bwdata_q <= wdata_q;
        end
      endcase
    end
  end

  assign bus.addr  = baddr_q;
  assign bus.mem   = mem_q;
  assign bus.rd    = req_q & ~wr_q;
  assign bus.wr    = req_q & wr_q;
  assign bus.wdata = bwdata_q;

endmodule

// ===== peripheral_control_status_checker.sv
`timescale 1ns/100ps
module peripheral_control_status_checker
  import peripheral_control_status_pkg::*;
(
  // Card bus
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [19:0] addr,
  input wire logic        mem,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----
  // Handshake
  // ----
  chk_ack_after_take: assert property ((rd || wr) && !ack |=> ack)
    else $error("ack late");
  chk_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack too long");
  chk_ack_has_cause: assert property (ack |-> $past(rd) || $past(wr))
    else $error("ack without request");
  chk_rd_wr_excl: assert property (!(rd && wr))
    else $error("read and write together");
  chk_req_held: assert property ((rd || wr) && !ack |=> $stable(addr) && $stable(mem)
    && $stable(wdata) && $stable(rd) && $stable(wr))
    else $error("request changed before ack");
  chk_req_dropped: assert property (ack |=> !rd && !wr)
    else $error("request held past ack");
  chk_rdata_holds: assert property (!(rd && !ack) |=> $stable(rdata))
    else $error("read data moved");
  chk_low_mem_zero: assert property (rd && mem && !ack && addr < ROM_BASE
    |=> rdata == 16'h0000)
    else $error("unmapped memory read not zero");
endmodule

// ===== scsi_adapter_control_status_tb_top.sv
`timescale 1ns/100ps
module scsi_adapter_control_status_tb_top;
  import peripheral_control_status_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dw = 32'h0, dr, v;
  logic        ack, irq, hirq_n, nmi;
  logic [3:0]  lirq;
  logic [8:0]  pin = 9'h000;
  logic [1:0]  be = 2'h3, bf = 2'h0, wfn = 2'h3, wan = 2'h3, st;
  logic [15:0] romd = 16'h1234, idv;
  int          err_total = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  peripheral_control_status_if bus_if ();
  peripheral_control_status_ctrl u_peripheral_control_status_ctrl (.mclk(mclk), .rst_n(rst_n), .wb_cyc(cyc), .wb_stb(stb),
    .wb_we(we), .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dw), .wb_dat_r(dr),
    .wb_ack(ack), .irq(irq), .bus(bus_if.cpu));
  peripheral_control_status_card u_peripheral_control_status_card (.mclk(mclk), .rst_n(rst_n), .bus(bus_if.card),
    .scsi_irq(pin[P_SPC]), .dma_fault(pin[P_FAULT]), .dma_eop1(pin[P_EOP1]),
    .dma_eop0(pin[P_EOP0]), .scsi_bus_reset(pin[P_BRST]), .host_ctrl_access(pin[P_CTRL]),
    .host_idvec_access(pin[P_IDV]), .host_iack(pin[P_IACK]), .host_irq_ack(pin[P_HACK]),
    .byte_empty(be), .byte_full(bf), .word_full_n(wfn), .word_avail_n(wan),
    .fifo_rdata(16'h0000), .fifo_wr(), .fifo_rd(), .fifo_word(), .fifo_sel(),
    .fifo_wdata(), .periph_chip_select_two(), .periph_chip_select_three(),
    .upper_chip_select(), .rom_word(), .rom_rdata(romd),
    .host_interrupt_request_n(hirq_n), .local_irq_zero(lirq[0]), .local_irq_one(lirq[1]),
    .local_irq_two(lirq[2]), .local_irq_three(lirq[3]), .local_nmi(nmi), .id_vector(idv));
  peripheral_control_status_checker u_peripheral_control_status_checker (.mclk(mclk), .rst_n(rst_n), .addr(bus_if.addr),
    .mem(bus_if.mem), .rd(bus_if.rd), .wr(bus_if.wr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .ack(bus_if.ack));
  // ----
  // Bus tasks
  // ----
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    @(negedge mclk);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
    @(posedge mclk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    // Ack read at the edge is its pre-edge value, the one the edge samples
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    v = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic op(input op_t c, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wb(1'b1, WB_ADDR, {12'h000, a});
    wb(1'b1, WB_WDATA, {16'h0000, d});
    wb(1'b1, WB_CMD, {29'h0, c});
    do begin
      wb(1'b0, WB_STATUS, 32'h0);
      n++;
    end while (v[1:0] === 2'h0 && n < 60);
    st = v[1:0];
    wb(1'b1, WB_STATUS, 32'h3);
    wb(1'b0, WB_RDATA, 32'h0);
  endtask
  function automatic logic [31:0] sx(logic wp, logic rp, logic h, logic [6:0] ev);
    return {16'h0, wp, rp, be[rp], bf[wp], wfn, wan, h, ~ev[6:2], ev[1:0]};
  endfunction
  task automatic pulse(input logic [8:0] p, input logic [8:0] hold);
    pin <= p;
    repeat (3) @(posedge mclk);
    pin <= hold;
    repeat (3) @(posedge mclk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_init();
    do wb(1'b0, WB_STATUS, 32'h0); while (v[S_BUSY] !== 1'b0);
    cmp("id", {16'h0, CARD_ID}, {16'h0, idv});
    be <= 2'h1; bf <= 2'h2; wfn <= 2'h1; wan <= 2'h2;
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("status", sx(0, 0, 1, 7'h00), v);
    $display("init done");
  endtask
  task automatic t_evt();
    logic [6:0] ev;
    ev = 7'h7F;
    pulse(9'h07F, 9'h010);
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("events", sx(0, 0, 1, ev), v);
    cmp("nmi", 32'h1, {31'h0, nmi});
    cmp("local irq", 32'hF, {28'h0, lirq});
    for (int n = 0; n < 6; n++) begin
      op(n[0] ? OP_IO_WR : OP_IO_RD, IO_CLR_BASE + 20'(n), 16'h0000);
      if (n != 2) ev[n] = 1'b0;
      op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
      cmp("clear", sx(0, 0, 1, ev), v);
    end
    op(OP_IO_RD, IO_SPC_IRQ, 16'h0000);
    pulse(9'h000, 9'h000);
    op(OP_IO_WR, IO_CLR_BASE + 20'h2, 16'h0000);
    ev = 7'h00;
    pulse(9'h080, 9'h0C0);
    pin <= 9'h000;
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("quiet", sx(0, 0, 1, ev), v);
    $display("events done");
  endtask
  task automatic t_host();
    op(OP_IO_WR, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("host req", 32'h0, {31'h0, hirq_n});
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("bit7", sx(0, 0, 0, 7'h00), v);
    op(OP_IO_RD, IO_CLR_BASE + 20'h7, 16'h0000);
    cmp("clr 48F", 32'h1, {31'h0, hirq_n});
    op(OP_IO_WR, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    pulse(9'h100, 9'h000);
    cmp("host ack", 32'h1, {31'h0, hirq_n});
    $display("host irq done");
  endtask
  task automatic t_ptr();
    op(OP_IO_WR, IO_BYTE_FIFO, 16'h00A5);
    op(OP_IO_RD, IO_BYTE_FIFO, 16'h0000);
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("ptr 11", sx(1, 1, 1, 7'h00), v);
    op(OP_IO_RD, IO_PS2_BASE, 16'h0000);
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("ptr 10", sx(1, 0, 1, 7'h00), v);
    op(OP_IO_WR, IO_PS3_BASE, 16'h0000);
    op(OP_IO_RD, IO_PERIPHERAL_CONTROL_STATUS, 16'h0000);
    cmp("ptr 00", sx(0, 0, 1, 7'h00), v);
    $display("pointers done");
  endtask
  task automatic t_chk();
    be <= 2'h3; bf <= 2'h3; wfn <= 2'h0; wan <= 2'h3;
    for (int i = 2; i < 8; i++)
      if (i != 6) begin
        op(op_t'(i), IO_BYTE_FIFO, 16'h0000);
        cmp("refused", 32'h2, {30'h0, st});
      end
    be <= 2'h0; bf <= 2'h0; wfn <= 2'h3; wan <= 2'h0;
    for (int i = 2; i < 6; i++) begin
      op(op_t'(i), IO_BYTE_FIFO, 16'h0000);
      cmp("done", 32'h1, {30'h0, st});
    end
    wb(1'b1, WB_MASK, 32'h2);
    wb(1'b1, WB_CMD, 32'h7);
    cmp("irq", 32'h1, {31'h0, irq});
    wb(1'b1, WB_MASK, 32'h0);
    cmp("masked", 32'h0, {31'h0, irq});
    wb(1'b1, WB_MASK, 32'h2);
    wb(1'b1, WB_STATUS, 32'h3);
    cmp("cleared", 32'h0, {31'h0, irq});
    wb(1'b0, 8'h1C, 32'h0);
    cmp("unmapped", 32'h0, v);
    op(OP_MEM_RD, ROM_BASE, 16'h0000);
    cmp("rom", {16'h0, romd}, v);
    op(OP_MEM_RD, 20'h10000, 16'h0000);
    cmp("low mem", 32'h0, v);
    $display("controller done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_init();
    t_evt();
    t_host();
    t_ptr();
    t_chk();
    test_done();
  end
endmodule
